// [crs_board_model.sv]
// board reset circuit and strap resistors facing the reset sequencer
`timescale 1ns/1ps
`include "crs_cfg.svh"
module crs_board_model (
    // clock
    input  wire logic                     mclk,
    // reset and straps to the device
    output logic                          system_reset_input_n,
    output logic [`CRS_STRAP_W-1:0]       strap_in
);
    ////////////////////////////////////////////////////////////////////////////
    // power-up: reset input low from time zero until supplies are valid
    initial begin
        system_reset_input_n = 1'b0;
        strap_in             = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one clean low pulse; straps drift first half, then settle and hold
    task automatic pulse(input int n, input logic [`CRS_STRAP_W-1:0] val);
        @(negedge mclk);
        system_reset_input_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            strap_in = (i < n / 2) ? (val ^ i[7:0] ^ 8'h5a) : val;
            @(negedge mclk);
        end
        system_reset_input_n = 1'b1; // straps left at val
    endtask

    // strap change only once reset output is high
    task automatic set_strap(input logic [`CRS_STRAP_W-1:0] val);
        strap_in = val;
    endtask
endmodule

// [crs_cfg.svh]
// field positions, reset values and timing counts of the reset sequencer
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// strap width and field positions
`define CRS_STRAP_W          8
`define CRS_STRAP_MODE_BIT   0

// reset values
`define CRS_STRAP_RST        8'h00
`define CRS_CNT_RST          4'h0

// counter width and timing counts in mclk cycles
`define CRS_CNT_W            4
`define CRS_BUS_START_CYC    4'h4
`define CRS_ISA_LAG_CYC      4'h4

`endif

// [crs_pkg.sv]
// types shared by the reset and strap sequencer
package crs_pkg;

    typedef enum logic [2:0] {
        CRS_ST_RESET   = 3'b000,
        CRS_ST_LOCK    = 3'b001,
        CRS_ST_RELEASE = 3'b010,
        CRS_ST_PCI     = 3'b011,
        CRS_ST_RUN     = 3'b100
    } crs_state_t;

    typedef enum logic {
        CRS_MODE_ISA   = 1'b0,
        CRS_MODE_LOCAL = 1'b1
    } crs_mode_t;

endpackage

// [crs_sequencer.sv]
// cold and warm reset sequencer with strap sampling on every cycle while reset input is low
`timescale 1ns/1ps
`include "crs_cfg.svh"
// Notes on behaviour
// RQ1: board holds reset input low until supplies valid, plus about ten microseconds; in the bench the first release comes at 64 ns.
// RQ2: straps sampled every cycle while reset input is low; latest value used.
// RQ3: board keeps straps steady while input low and until reset output rises; the board model drifts them for the first half of each pulse.
// RQ4: no bus activity until a few cycles after reset output is released.
// RQ5: in isa mode pci activity comes before any isa activity.
// RQ6: in local bus mode pci stays idle; flash chip select is first activity.
// RQ7: warm reset follows the same strap and bus ordering as cold reset.
// RQ8: board sizes warm reset pulse for strap resistor settling.
// RQ9: board delivers a glitch-free reset input pulse.
// RQ10: pci clock pll runs open loop while reset input is asserted.
// RQ11: reset output held low, released on mclk after pll lock and strap latch.
module crs_sequencer #(
    parameter int STRAP_W = `CRS_STRAP_W
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    // board reset and straps
    input  wire logic                 system_reset_input_n,
    input  wire logic [STRAP_W-1:0]   strap_in,
    // pll status
    input  wire logic                 pll_lock,
    // reset and configuration out
    output logic                      system_reset_output_n,
    output logic [STRAP_W-1:0]        strap_cfg,
    output crs_pkg::crs_mode_t        bus_mode,
    output logic                      pci_pll_open_loop,
    // bus activity enables
    output logic                      pci_bus_en,
    output logic                      isa_bus_en,
    output logic                      flash_cs_en
);
    import crs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    crs_state_t                 state_q;
    crs_state_t                 state_d;
    logic [`CRS_CNT_W-1:0]      cnt_q;
    logic [`CRS_CNT_W-1:0]      cnt_d;
    logic [STRAP_W-1:0]         strap_q;
    logic [STRAP_W-1:0]         strap_d;
    logic                       rst_out_q;
    logic                       rst_out_d;
    logic                       open_loop_q;
    logic                       open_loop_d;
    logic                       pci_en_q;
    logic                       pci_en_d;
    logic                       isa_en_q;
    logic                       isa_en_d;
    logic                       flash_en_q;
    logic                       flash_en_d;
    logic                       local_mode;

    assign local_mode = strap_q[`CRS_STRAP_MODE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        strap_d     = strap_q;
        rst_out_d   = rst_out_q;
        open_loop_d = open_loop_q;
        pci_en_d    = pci_en_q;
        isa_en_d    = isa_en_q;
        flash_en_d  = flash_en_q;
        if (!system_reset_input_n) begin
            // any low input, cold or warm, restarts the whole sequence
            state_d     = CRS_ST_RESET;                                          // RQ7
            strap_d     = strap_in;                                              // RQ2
            cnt_d       = `CRS_CNT_RST;
            rst_out_d   = 1'b0;                                                  // RQ11
            open_loop_d = 1'b1;                                                  // RQ10
            pci_en_d    = 1'b0;                                                  // RQ4
            isa_en_d    = 1'b0;
            flash_en_d  = 1'b0;
        end else begin
            open_loop_d = 1'b0;
            case (state_q)
                CRS_ST_RESET: begin
                    // straps now frozen at the last sample taken while low
                    state_d = CRS_ST_LOCK;
                end
                CRS_ST_LOCK: begin
                    if (pll_lock) begin
                        state_d   = CRS_ST_RELEASE;
                        rst_out_d = 1'b1;                                        // RQ11
                        cnt_d     = `CRS_CNT_RST;
                    end
                end
                CRS_ST_RELEASE: begin
                    // quiet gap after release so downstream logic leaves reset first
                    if (cnt_q == `CRS_BUS_START_CYC - 4'h1) begin                // RQ4
                        cnt_d = `CRS_CNT_RST;
                        if (local_mode) begin
                            state_d    = CRS_ST_RUN;
                            flash_en_d = 1'b1;                                   // RQ6
                        end else begin
                            state_d  = CRS_ST_PCI;
                            pci_en_d = 1'b1;                                     // RQ5
                        end
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                CRS_ST_PCI: begin
                    // isa sits behind the south bridge, so it trails pci
                    if (cnt_q == `CRS_ISA_LAG_CYC - 4'h1) begin                  // RQ5
                        state_d  = CRS_ST_RUN;
                        isa_en_d = 1'b1;
                        cnt_d    = `CRS_CNT_RST;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                CRS_ST_RUN: begin
                    state_d = CRS_ST_RUN;
                end
                default: begin
                    state_d   = CRS_ST_RESET;
                    rst_out_d = 1'b0;
                    pci_en_d  = 1'b0;
                    isa_en_d  = 1'b0;
                    flash_en_d = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q     <= CRS_ST_RESET;
            cnt_q       <= `CRS_CNT_RST;
            strap_q     <= `CRS_STRAP_RST;
            rst_out_q   <= 1'b0;
            open_loop_q <= 1'b1;
            pci_en_q    <= 1'b0;
            isa_en_q    <= 1'b0;
            flash_en_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            strap_q     <= strap_d;
            rst_out_q   <= rst_out_d;
            open_loop_q <= open_loop_d;
            pci_en_q    <= pci_en_d;
            isa_en_q    <= isa_en_d;
            flash_en_q  <= flash_en_d;
        end
    end

    assign system_reset_output_n = rst_out_q;
    assign strap_cfg             = strap_q;
    assign bus_mode              = crs_mode_t'(local_mode);
    assign pci_pll_open_loop     = open_loop_q;
    assign pci_bus_en            = pci_en_q;
    assign isa_bus_en            = isa_en_q;
    assign flash_cs_en           = flash_en_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_strap_track;
        @(posedge mclk) disable iff (!rst_b)
        !system_reset_input_n |=> strap_cfg == $past(strap_in);
    endproperty
    a_strap_track: assert property (p_strap_track) // RQ2
        else $error("strap not sampled during reset input low");

    property p_strap_frozen;
        @(posedge mclk) disable iff (!rst_b)
        $past(system_reset_input_n) |-> $stable(strap_cfg);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen) // RQ2
        else $error("strap changed after reset input released");

    property p_rst_out_low;
        @(posedge mclk) disable iff (!rst_b)
        !system_reset_input_n |=> !system_reset_output_n;
    endproperty
    a_rst_out_low: assert property (p_rst_out_low) // RQ11
        else $error("reset output high while input low");

    property p_release_lock;
        @(posedge mclk) disable iff (!rst_b)
        $rose(system_reset_output_n) |-> $past(pll_lock) && $past(system_reset_input_n, 2);
    endproperty
    a_release_lock: assert property (p_release_lock) // RQ11
        else $error("reset output released without lock or strap latch");

    property p_bus_quiet;
        @(posedge mclk) disable iff (!rst_b)
        $rose(system_reset_output_n) |-> (!pci_bus_en && !isa_bus_en && !flash_cs_en)[*4];
    endproperty
    a_bus_quiet: assert property (p_bus_quiet) // RQ4
        else $error("bus active too soon after reset release");

    property p_isa_after_pci;
        @(posedge mclk) disable iff (!rst_b)
        $rose(isa_bus_en) |-> pci_bus_en && $past(pci_bus_en, 4);
    endproperty
    a_isa_after_pci: assert property (p_isa_after_pci) // RQ5
        else $error("isa activity not preceded by pci");

    property p_local_no_pci;
        @(posedge mclk) disable iff (!rst_b)
        bus_mode == CRS_MODE_LOCAL |-> !pci_bus_en && !isa_bus_en;
    endproperty
    a_local_no_pci: assert property (p_local_no_pci) // RQ6
        else $error("pci touched in local bus mode");

    property p_warm_quiet;
        @(posedge mclk) disable iff (!rst_b)
        !system_reset_input_n |=> !pci_bus_en && !isa_bus_en && !flash_cs_en;
    endproperty
    a_warm_quiet: assert property (p_warm_quiet) // RQ7
        else $error("bus active during warm reset");

    property p_open_loop;
        @(posedge mclk) disable iff (!rst_b)
        !system_reset_input_n |=> pci_pll_open_loop;
    endproperty
    a_open_loop: assert property (p_open_loop) // RQ10
        else $error("pci pll not open loop during reset");

    c_isa_boot: cover property (@(posedge mclk) disable iff (!rst_b) $rose(isa_bus_en));
    c_local_boot: cover property (@(posedge mclk) disable iff (!rst_b) $rose(flash_cs_en));
    c_warm_reset: cover property (@(posedge mclk) disable iff (!rst_b)
        pci_bus_en ##1 !system_reset_input_n);

endmodule

// [tb_top.sv]
// self-checking bench for the reset and strap sequencer
`timescale 1ns/1ps
`include "crs_cfg.svh"
module tb_top;
    import crs_pkg::*;
    logic            mclk, rst_b, pll_lock, rst_in_n, rst_out_n, open_loop;
    logic            pci_en, isa_en, flash_en, prev_out, mode;
    logic [7:0]      strap, cfg, exp_v, v;
    crs_mode_t       bus_mode;
    logic [7:0]      exp_q[$];
    int              n_mismatch = 0, num_checks = 0, cnt;
    integer          seed = 32'hf24656ac;

    crs_board_model u_board (.mclk(mclk), .system_reset_input_n(rst_in_n), .strap_in(strap));
    crs_sequencer uut (.mclk(mclk), .rst_b(rst_b), .system_reset_input_n(rst_in_n),
        .strap_in(strap), .pll_lock(pll_lock), .system_reset_output_n(rst_out_n),
        .strap_cfg(cfg), .bus_mode(bus_mode), .pci_pll_open_loop(open_loop),
        .pci_bus_en(pci_en), .isa_bus_en(isa_en), .flash_cs_en(flash_en));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // bounded wait on a condition sampled at falling edges
    task automatic wait_for(input int which);
        cnt = 0;
        while (!((which == 0) ? (pci_en | flash_en) : isa_en) && cnt < 20) begin
            @(negedge mclk);
            cnt++;
        end
        if (cnt >= 20) begin
            check("bus wait timeout", 8'h01, 8'h00);
            report_and_stop();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watcher: each reset output release consumes one expected strap note
    initial begin
        prev_out = 1'b0;
        forever begin
            @(negedge mclk);
            if (prev_out === 1'b0 && rst_out_n === 1'b1 && exp_q.size() > 0) begin
                exp_v = exp_q.pop_front();
                mode  = exp_v[0];
                check("strap_cfg", cfg, exp_v);
                check("bus_mode", 8'(bus_mode), 8'(mode));
                check("enables at release", {pci_en, isa_en, flash_en}, 8'h00);
                wait_for(0);
                check("bus start delay", 8'(cnt), 8'(`CRS_BUS_START_CYC));
                check("first bus", {pci_en, isa_en, flash_en}, mode ? 8'h01 : 8'h04);
                if (mode == 1'b0) begin
                    wait_for(1);
                    check("isa lag", 8'(cnt), 8'(`CRS_ISA_LAG_CYC));
                end else begin
                    repeat (8) @(negedge mclk);
                    check("local pci idle", {pci_en, isa_en}, 8'h00);
                end
            end
            prev_out = rst_out_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one reset pulse, lock held off for lock_dly + 2 cycles after release, high throughout if lock_dly is 0
    task automatic run(input int n, input logic [7:0] val, input int lock_dly);
        exp_q.push_back(val);
        pll_lock = (lock_dly == 0);
        u_board.pulse(n, val);
        check("out held", {rst_out_n, open_loop, pci_en, isa_en, flash_en}, 8'h08);
        check("latest strap", cfg, val);
        repeat (2) @(negedge mclk);
        check("pll loop closed", 8'(open_loop), 8'h00);
        repeat (lock_dly) begin
            check("out before lock", 8'(rst_out_n), 8'h00);
            @(negedge mclk);
        end
        pll_lock = 1'b1;
        repeat (26) @(negedge mclk);
        $display("test done: strap %h lock delay %0d", val, lock_dly);
    endtask

    initial begin
        rst_b    = 1'b0;
        pll_lock = 1'b0;
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        run(12, 8'h00, 3); // cold start, isa
        u_board.set_strap(8'hff);
        repeat (3) @(negedge mclk);
        check("strap ignored high", cfg, 8'h00);
        $display("test done: straps ignored while running");
        pll_lock = 1'b0;
        u_board.pulse(4, 8'h33);
        repeat (4) @(negedge mclk);
        run(5, 8'h81, 2); // warm reset during lock wait
        for (int i = 0; i < 6; i++) begin
            v    = 8'($random(seed));
            v[0] = i[0];
            run(2 + (i % 5), v, i % 3);
        end
        check("notes left", 8'(exp_q.size()), 8'h00);
        report_and_stop();
    end
endmodule
